/* logic/host_port_pkg.sv */
// Shared constants and types for the host memory-access port read path
package host_port_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W    = 16;         // Port word width
    localparam int unsigned ADDR_W    = 14;         // Internal word address width
    localparam int unsigned MEM_DEPTH = 2 ** ADDR_W; // Words behind the port
    localparam int unsigned MODE_W    = 4;          // Mode pins A..D
    localparam int unsigned PIN_W     = 4 + DATA_W + MODE_W; // Synchronised pin bundle

    // ------------------------------------------------------------------
    // Register map (core data space)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OVERLAY_ADDR = 14'h3fe7; // Port overlay control
    localparam logic [ADDR_W-1:0] STATUS_ADDR  = 14'h3fe8; // Port status word
    localparam logic [DATA_W-1:0] OVERLAY_RST  = 16'h0000; // Overlay reset value
    localparam int unsigned       SROM_BIT     = 14;       // Short-read-only enable

    // ------------------------------------------------------------------
    // Mode pin positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned       MODE_C_BIT = 2;      // Mode C selects port pins
    localparam logic [MODE_W-1:0] MODE_RST   = 4'h0;   // Mode bits before capture

    // ------------------------------------------------------------------
    // Port sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,  // Ready, acknowledge low
        ST_READ  = 3'b001,  // Driving previously fetched word
        ST_WRITE = 3'b010,  // Host write in progress
        ST_FETCH = 3'b011,  // Memory read issued
        ST_LOAD  = 3'b100   // Fetched word captured
    } port_state_e;
endpackage

/* logic/port_mem_if.sv */
// Memory access signals between the port sequencer and its word store
`timescale 1ns/100ps
`default_nettype none
interface port_mem_if;
    import host_port_pkg::*;
    logic              rd_en;    // Read request
    logic [ADDR_W-1:0] rd_addr;  // Read word address
    logic [DATA_W-1:0] rd_data;  // Read word, one cycle after request
    logic              wr_en;    // Write request
    logic [ADDR_W-1:0] wr_addr;  // Write word address
    logic [DATA_W-1:0] wr_data;  // Write word

    modport ctl (output rd_en, rd_addr, wr_en, wr_addr, wr_data, input rd_data);
    modport mem (input rd_en, rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface
`default_nettype wire

/* logic/port_word_mem.sv */
// Word store reached through the host port
`timescale 1ns/100ps
`default_nettype none
module port_word_mem
    import host_port_pkg::*;
(
    input  wire logic  i_core_clk,
    port_mem_if.mem    mem_port
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] word_ram [0:MEM_DEPTH-1]; // Not reset: contents are data

    // Registered read, one cycle latency
    always_ff @(posedge i_core_clk) begin
        if (mem_port.rd_en) begin
            mem_port.rd_data <= word_ram[mem_port.rd_addr];
        end
    end

    // Write port
    always_ff @(posedge i_core_clk) begin
        if (mem_port.wr_en) begin
            word_ram[mem_port.wr_addr] <= mem_port.wr_data;
        end
    end
endmodule
`default_nettype wire

/* logic/host_port_short_read_only.sv */
// Host memory-access port: short-read-only read path and mode pin capture
//
// Contract
// [R1] Overlay bit 14 at 0x3FE7 enables short-read-only.
// [R2] Core and host may both write bit.
// [R3] Short-read-only mode off after reset.
// [R4] Select and read low: drive previous word.
// [R5] Select or read high ends, bus released.
// [R6] Acknowledge goes high once read begins.
// [R7] Host waits for acknowledge low first.
// [R8] Mode C one routes pins to port.
// [R9] Mode pins captured at reset release, kept.
// [R10] After read: prefetch, advance address, acknowledge low.
`timescale 1ns/100ps
`default_nettype none
module host_port_short_read_only
    import host_port_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    input  wire logic [MODE_W-1:0] i_mode_pins,
    input  wire logic              i_port_select_n,
    input  wire logic              i_port_read_strobe_n,
    input  wire logic              i_port_write_strobe_n,
    input  wire logic              i_port_addr_latch,
    input  wire logic [DATA_W-1:0] i_port_addr_data_bus,
    output logic      [DATA_W-1:0] o_port_addr_data_bus,
    output logic                   o_port_addr_data_oe,
    output logic                   o_port_ack_n,
    output logic                   o_port_pins_active,
    input  wire logic [ADDR_W-1:0] i_core_addr,
    input  wire logic              i_core_wr_en,
    input  wire logic              i_core_rd_en,
    input  wire logic [DATA_W-1:0] i_core_wdata,
    output logic      [DATA_W-1:0] o_core_rdata
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    port_mem_if                mem_bus ();        // Link to the word store
    logic [PIN_W-1:0]          pin_meta_ff;       // First synchroniser stage
    logic [PIN_W-1:0]          pin_sync_ff;       // Second synchroniser stage
    logic                      sel_n;             // Synchronised select
    logic                      rd_n;              // Synchronised read strobe
    logic                      wr_n;              // Synchronised write strobe
    logic                      addr_latch;        // Synchronised address latch
    logic [DATA_W-1:0]         bus_in;            // Synchronised bus
    logic [MODE_W-1:0]         mode_in;           // Synchronised mode pins
    logic [MODE_W-1:0]         mode_ff;           // Captured mode bits
    logic                      mode_taken_ff;     // Capture done
    logic                      port_on;           // Pins serve the port
    logic [DATA_W-1:0]         overlay_ff;        // Overlay control register
    logic                      srom_on;           // Short-read-only enabled
    port_state_e               state_ff;          // Sequencer state
    port_state_e               nxt_state;         // Next sequencer state
    logic [ADDR_W-1:0]         addr_ff;           // Internal port address
    logic [DATA_W-1:0]         prefetch_ff;       // Previously fetched word
    logic [DATA_W-1:0]         wdata_ff;          // Host write data
    logic                      read_start;        // Read begins
    logic                      write_start;       // Write begins
    logic                      read_end;          // Select or read high
    logic                      write_end;         // Select or write high
    logic                      host_reg_wr;       // Host writes overlay
    logic                      core_reg_wr;       // Core writes overlay

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // No reset: the chain must carry the mode pins through reset
    always_ff @(posedge i_core_clk) begin
        pin_meta_ff <= {i_mode_pins, i_port_addr_data_bus, i_port_addr_latch,
                        i_port_write_strobe_n, i_port_read_strobe_n, i_port_select_n};
        pin_sync_ff <= pin_meta_ff;
    end

    assign sel_n      = pin_sync_ff[0];
    assign rd_n       = pin_sync_ff[1];
    assign wr_n       = pin_sync_ff[2];
    assign addr_latch = pin_sync_ff[3];
    assign bus_in     = pin_sync_ff[4 +: DATA_W];
    assign mode_in    = pin_sync_ff[4 + DATA_W +: MODE_W];

    // ------------------------------------------------------------------
    // Mode capture
    // ------------------------------------------------------------------
    // Taken on the first edge after release, then frozen
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            mode_ff       <= MODE_RST;
            mode_taken_ff <= 1'b0;
        end else if (!mode_taken_ff) begin
            mode_ff       <= mode_in;                     // R9
            mode_taken_ff <= 1'b1;
        end
    end

    assign port_on = mode_taken_ff & mode_ff[MODE_C_BIT]; // R8

    // ------------------------------------------------------------------
    // Overlay control register
    // ------------------------------------------------------------------
    assign host_reg_wr = (state_ff == ST_WRITE) && write_end && (addr_ff == OVERLAY_ADDR);
    assign core_reg_wr = i_core_wr_en && (i_core_addr == OVERLAY_ADDR);
    assign srom_on     = overlay_ff[SROM_BIT];            // R1

    // Host write wins when both land together
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            overlay_ff <= OVERLAY_RST;                    // R3
        end else if (host_reg_wr) begin
            overlay_ff <= wdata_ff;                       // R2
        end else if (core_reg_wr) begin
            overlay_ff <= i_core_wdata;                   // R2
        end
    end

    // Core read: overlay, status, else zero
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_core_rdata <= 16'h0000;
        end else if (i_core_rd_en) begin
            if (i_core_addr == OVERLAY_ADDR) begin
                o_core_rdata <= overlay_ff;
            end else if (i_core_addr == STATUS_ADDR) begin
                o_core_rdata <= {9'h000, state_ff, mode_ff};
            end else begin
                o_core_rdata <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Reads are only served with mode C and short-read-only both on
    assign read_start  = port_on && srom_on && !sel_n && !rd_n;  // R4
    assign write_start = port_on && !sel_n && !wr_n;
    assign read_end    = sel_n || rd_n;                          // R5
    assign write_end   = sel_n || wr_n;

    // Next state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                // A host starting early is still caught here
                if (port_on && addr_latch) begin
                    nxt_state = ST_FETCH;
                end else if (read_start) begin
                    nxt_state = ST_READ;                   // R7
                end else if (write_start) begin
                    nxt_state = ST_WRITE;
                end
            end
            ST_READ: begin
                if (read_end) begin
                    nxt_state = ST_FETCH;                  // R10
                end
            end
            ST_WRITE: begin
                if (write_end) begin
                    nxt_state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                nxt_state = ST_LOAD;
            end
            ST_LOAD: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;                       // Illegal code recovery
            end
        endcase
    end

    // State register
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Port address: latched by host, advanced after each access
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            addr_ff <= 14'h0000;
        end else if (state_ff == ST_IDLE && port_on && addr_latch) begin
            addr_ff <= bus_in[ADDR_W-1:0];
        end else if ((state_ff == ST_READ && read_end) ||
                     (state_ff == ST_WRITE && write_end)) begin
            addr_ff <= addr_ff + 14'h0001;                // R10
        end
    end

    // Write data sampled while the strobe is still low
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            wdata_ff <= 16'h0000;
        end else if (state_ff == ST_WRITE && !write_end) begin
            wdata_ff <= bus_in;
        end
    end

    // Prefetched word, held stable through the next read
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            prefetch_ff <= 16'h0000;
        end else if (state_ff == ST_LOAD) begin
            prefetch_ff <= mem_bus.rd_data;               // R10
        end
    end

    // ------------------------------------------------------------------
    // Word store
    // ------------------------------------------------------------------
    assign mem_bus.rd_en   = (state_ff == ST_FETCH);     // R10
    assign mem_bus.rd_addr = addr_ff;
    assign mem_bus.wr_en   = (state_ff == ST_WRITE) && write_end && (addr_ff != OVERLAY_ADDR);
    assign mem_bus.wr_addr = addr_ff;
    assign mem_bus.wr_data = wdata_ff;

    port_word_mem u_word_mem (
        .i_core_clk (i_core_clk),
        .mem_port   (mem_bus.mem)
    );

    // ------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------
    // Ack and enable registered from next state so they follow the state exactly
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_port_ack_n        <= 1'b1;
            o_port_addr_data_oe <= 1'b0;
            o_port_pins_active  <= 1'b0;
        end else begin
            o_port_ack_n        <= !port_on || (nxt_state != ST_IDLE); // R6
            o_port_addr_data_oe <= (nxt_state == ST_READ);             // R4 R5
            o_port_pins_active  <= port_on;                            // R8
        end
    end

    // Bus value only matters while the enable is high
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_port_addr_data_bus <= 16'h0000;
        end else begin
            o_port_addr_data_bus <= (state_ff == ST_LOAD) ? mem_bus.rd_data : prefetch_ff;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_read_gated_mode: assert property ((state_ff == ST_IDLE) && (nxt_state == ST_READ)
        |-> srom_on && port_on) else $error("read served without mode"); // R1
    a_core_reg_write: assert property (core_reg_wr && !host_reg_wr
        |=> overlay_ff == $past(i_core_wdata)) else $error("core write lost"); // R2
    a_host_reg_write: assert property (host_reg_wr
        |=> overlay_ff == $past(wdata_ff)) else $error("host write lost"); // R2
    a_srom_reset_off: assert property (!mode_taken_ff |-> !srom_on)
        else $error("mode on after reset"); // R3
    a_read_drive_word: assert property ((state_ff == ST_READ)
        |-> o_port_addr_data_oe && (o_port_addr_data_bus == prefetch_ff))
        else $error("read word not driven"); // R4
    a_read_end_release: assert property ((state_ff == ST_READ) && read_end
        |=> !o_port_addr_data_oe) else $error("bus not released"); // R5
    a_ack_busy_read: assert property ((state_ff == ST_READ) |-> o_port_ack_n)
        else $error("ack low during read"); // R6
    a_pins_idle_off: assert property (!port_on |=> o_port_ack_n && !o_port_addr_data_oe)
        else $error("pins active without mode C"); // R8
    a_mode_bits_hold: assert property (mode_taken_ff |=> $stable(mode_ff))
        else $error("mode bits changed"); // R9
    a_prefetch_order: assert property ((state_ff == ST_READ) && read_end
        |=> (state_ff == ST_FETCH) && (addr_ff == $past(addr_ff) + 14'h0001)
        ##1 (state_ff == ST_LOAD) ##1 (state_ff == ST_IDLE) && !o_port_ack_n)
        else $error("prefetch sequence broken"); // R10

    c_short_read: cover property ((state_ff == ST_READ) ##1 (state_ff == ST_FETCH));
    c_host_write: cover property (host_reg_wr);
    c_addr_latch: cover property ((state_ff == ST_IDLE) && port_on && addr_latch);
    c_srom_enable: cover property ($rose(srom_on));
endmodule
`default_nettype wire

/* tb/host_cpu_model.sv */
// Behavioural external host that drives the port pins
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model
    import host_port_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_port_ack_n,
    input  wire logic              i_port_oe,
    input  wire logic [DATA_W-1:0] i_port_bus,
    output logic                   o_select_n,
    output logic                   o_read_n,
    output logic                   o_write_n,
    output logic                   o_addr_latch,
    output logic                   o_drive_en,
    output logic      [DATA_W-1:0] o_drive_val
);
    // ------------------------------------------------------------------
    // Pins idle until a task asks for an access
    // ------------------------------------------------------------------
    initial begin
        o_select_n   = 1'b1;
        o_read_n     = 1'b1;
        o_write_n    = 1'b1;
        o_addr_latch = 1'b0;
        o_drive_en   = 1'b0;
        o_drive_val  = 16'h0000;
    end

    // One cycle, then a small skew so pins never move on the edge
    task automatic step;
        @(posedge i_core_clk);
        #1;
    endtask

    // Bounded wait for ready; every access task but try_read ends here so the next starts legally
    task automatic wait_ready(output logic ok);
        int n;
        n = 0;
        while (i_port_ack_n !== 1'b0 && n < 40) begin
            step();
            n++;
        end
        ok = (i_port_ack_n === 1'b0);
    endtask

    // Address phase: word address on the bus while the latch is high
    task automatic latch_addr(input logic [ADDR_W-1:0] a);
        logic ok;
        o_drive_val  = {2'b00, a};
        o_drive_en   = 1'b1;
        o_addr_latch = 1'b1;
        repeat (3) step();
        o_addr_latch = 1'b0;
        repeat (3) step();
        o_drive_en = 1'b0;
        repeat (2) step();
        wait_ready(ok);
    endtask

    // Write: data held past the end because the port samples it late
    task automatic write_word(input logic [DATA_W-1:0] d, output logic ok);
        int n;
        logic rdy;
        o_drive_val = d;
        o_drive_en  = 1'b1;
        o_select_n  = 1'b0;
        o_write_n   = 1'b0;
        n = 0;
        while (i_port_ack_n !== 1'b1 && n < 10) begin
            step();
            n++;
        end
        ok = (i_port_ack_n === 1'b1);
        repeat (2) step();
        o_select_n = 1'b1;
        o_write_n  = 1'b1;
        repeat (3) step();
        o_drive_en = 1'b0;
        wait_ready(rdy);
        ok = ok & rdy;
    endtask

    // Read: take the word, watch it stay put, then see the bus released
    task automatic read_word(output logic [DATA_W-1:0] d, output logic held,
                             output logic ok);
        int n;
        logic rdy;
        o_select_n = 1'b0;
        o_read_n   = 1'b0;
        n = 0;
        while (!(i_port_ack_n === 1'b1 && i_port_oe === 1'b1) && n < 10) begin
            step();
            n++;
        end
        d    = i_port_bus;
        held = (i_port_oe === 1'b1);
        repeat (3) begin
            step();
            if (i_port_bus !== d || i_port_oe !== 1'b1) held = 1'b0;
        end
        // Both strobes rise together so the next read never glitches select
        o_read_n   = 1'b1;
        o_select_n = 1'b1;
        n = 0;
        while (i_port_oe !== 1'b0 && n < 6) begin
            step();
            n++;
        end
        ok = (i_port_oe === 1'b0);
        wait_ready(rdy);
        ok = ok & rdy;
    endtask

    // Read that the port should refuse; reports any drive or busy seen
    task automatic try_read(output logic seen_oe, output logic seen_busy);
        seen_oe   = 1'b0;
        seen_busy = 1'b0;
        o_select_n = 1'b0;
        o_read_n   = 1'b0;
        repeat (6) begin
            step();
            if (i_port_oe !== 1'b0) seen_oe = 1'b1;
            if (i_port_ack_n !== 1'b0) seen_busy = 1'b1;
        end
        o_select_n = 1'b1;
        o_read_n   = 1'b1;
        repeat (4) step();
    endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the short-read-only host port
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import host_port_pkg::*;
    // ------------------------------------------------------------------
    // Bench signals
    // ------------------------------------------------------------------
    logic              core_clk, rst_n;     // Clock and reset
    logic [MODE_W-1:0] mode_pins;           // Mode pins A..D
    logic              sel_n, rd_n, wr_n;   // Host strobes
    logic              latch, host_en;      // Host latch and drive
    logic [DATA_W-1:0] host_val, bus_in;    // Host value, wire level
    logic [DATA_W-1:0] dev_bus;             // Device drive
    logic [DATA_W-1:0] float_pat = 16'h0000; // Floating noise, one driver
    logic              dev_oe, ack_n;       // Device enable, acknowledge
    logic              pins_active;         // Shared pins on port
    logic [ADDR_W-1:0] core_addr;           // Core address
    logic              core_wr_en, core_rd_en;
    logic [DATA_W-1:0] core_wdata, core_rdata;
    int                fail_count, checks, seed;
    logic [DATA_W-1:0] words [6];           // Words written through the port
    logic [DATA_W-1:0] d, wv;
    logic [ADDR_W-1:0] base;
    logic              ok, held, f_oe, f_busy;

    // Nobody drives: the wire wanders rather than keep a stale word
    assign bus_in = dev_oe ? dev_bus : (host_en ? host_val : float_pat);
    always @(posedge core_clk) float_pat <= float_pat + 16'h1357;

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    host_port_short_read_only uut (
        .i_core_clk(core_clk), .i_rst_n(rst_n), .i_mode_pins(mode_pins),
        .i_port_select_n(sel_n), .i_port_read_strobe_n(rd_n),
        .i_port_write_strobe_n(wr_n), .i_port_addr_latch(latch),
        .i_port_addr_data_bus(bus_in), .o_port_addr_data_bus(dev_bus),
        .o_port_addr_data_oe(dev_oe), .o_port_ack_n(ack_n),
        .o_port_pins_active(pins_active), .i_core_addr(core_addr),
        .i_core_wr_en(core_wr_en), .i_core_rd_en(core_rd_en),
        .i_core_wdata(core_wdata), .o_core_rdata(core_rdata));

    host_cpu_model host (
        .i_core_clk(core_clk), .i_port_ack_n(ack_n), .i_port_oe(dev_oe),
        .i_port_bus(dev_bus), .o_select_n(sel_n), .o_read_n(rd_n),
        .o_write_n(wr_n), .o_addr_latch(latch), .o_drive_en(host_en),
        .o_drive_val(host_val));

    // ------------------------------------------------------------------
    // Comparison, expectation and core bus helpers
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [DATA_W-1:0] exp,
                         input logic [DATA_W-1:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Pins serve the port only when mode C was high at release
    function automatic logic port_expected(input logic [MODE_W-1:0] m);
        return m[MODE_C_BIT];
    endfunction

    task automatic core_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        core_addr  = a;
        core_wdata = v;
        core_wr_en = 1'b1;
        host.step();
        core_wr_en = 1'b0;
    endtask

    // Read data is registered, so it is taken one edge after the strobe
    task automatic core_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        core_addr  = a;
        core_rd_en = 1'b1;
        host.step();
        core_rd_en = 1'b0;
        v = core_rdata;
        host.step(); // Idle edge: a following read must see the strobe drop
    endtask

    task automatic do_reset(input logic [MODE_W-1:0] m);
        mode_pins = m;
        rst_n = 1'b0;
        repeat (6) host.step();
        check("ack_n in reset", 16'h0001, DATA_W'(ack_n));
        rst_n = 1'b1;
        repeat (3) host.step();
        mode_pins = ~m; // later pin changes must not matter
        repeat (3) host.step();
        check("pins_active", DATA_W'(port_expected(m)), DATA_W'(pins_active));
        check("ack_n after reset", DATA_W'(!port_expected(m)), DATA_W'(ack_n));
    endtask

    task automatic print_verdict;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        #400000;
        fail_count++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 38616;
        fail_count = 0;
        checks = 0;
        core_addr = 14'h0000;
        core_wr_en = 1'b0;
        core_rd_en = 1'b0;
        core_wdata = 16'h0000;
        do_reset(4'h4);
        core_read(OVERLAY_ADDR, d);
        check("overlay reset", OVERLAY_RST, d);
        core_read(STATUS_ADDR, d);
        check("status word", 16'h0004, d);
        host.try_read(f_oe, f_busy);
        check("read while off", 16'h0000, DATA_W'({f_oe, f_busy}));
        wv = 16'($random(seed)) | 16'h4000;
        core_write(OVERLAY_ADDR, wv);
        core_read(OVERLAY_ADDR, d);
        check("overlay core write", wv, d);
        core_read(14'h0123, d);
        check("unmapped read", 16'h0000, d);
        base = 14'($random(seed)) & 14'h0fff;
        host.latch_addr(base);
        for (int i = 0; i < 6; i++) begin
            words[i] = 16'($random(seed));
            host.write_word(words[i], ok);
            check("write handshake", 16'h0001, DATA_W'(ok));
        end
        host.latch_addr(base);
        for (int i = 0; i < 6; i++) begin
            host.read_word(d, held, ok);
            check("read word", words[i], d);
            check("word held", 16'h0001, DATA_W'(held));
            check("bus released", 16'h0001, DATA_W'(ok));
        end
        host.latch_addr(OVERLAY_ADDR);
        host.write_word(16'h0000, ok);
        core_read(OVERLAY_ADDR, d);
        check("overlay host write", 16'h0000, d);
        host.try_read(f_oe, f_busy);
        check("read after clear", 16'h0000, DATA_W'({f_oe, f_busy}));
        do_reset(4'($random(seed)) & 4'hb);
        host.try_read(f_oe, f_busy);
        check("drive with mode C low", 16'h0000, DATA_W'(f_oe));
        print_verdict();
    end
endmodule
`default_nettype wire
